// file: design/tmon_pkg.sv
package tmon_pkg;
  // ------------------------------------------------------------
  // register addresses (read and write sides differ for some)
  // ------------------------------------------------------------
  localparam logic [7:0] RD_LOC_VAL = 8'h00;
  localparam logic [7:0] RD_REM_HI = 8'h01;
  localparam logic [7:0] RD_STATUS = 8'h02;
  localparam logic [7:0] RD_SETUP = 8'h03;
  localparam logic [7:0] RD_RATE = 8'h04;
  localparam logic [7:0] RD_LOC_UL = 8'h05;
  localparam logic [7:0] RD_LOC_LL = 8'h06;
  localparam logic [7:0] RD_REM_UL_HI = 8'h07;
  localparam logic [7:0] RD_REM_LL_HI = 8'h08;
  localparam logic [7:0] WR_SETUP = 8'h09;
  localparam logic [7:0] WR_RATE = 8'h0a;
  localparam logic [7:0] WR_LOC_UL = 8'h0b;
  localparam logic [7:0] WR_LOC_LL = 8'h0c;
  localparam logic [7:0] WR_REM_UL_HI = 8'h0d;
  localparam logic [7:0] WR_REM_LL_HI = 8'h0e;
  localparam logic [7:0] WR_ONE_SHOT = 8'h0f;
  localparam logic [7:0] RD_REM_LO = 8'h10;
  localparam logic [7:0] A_OFS_HI = 8'h11;
  localparam logic [7:0] A_OFS_LO = 8'h12;
  localparam logic [7:0] A_REM_UL_LO = 8'h13;
  localparam logic [7:0] A_REM_LL_LO = 8'h14;
  localparam logic [7:0] A_REM_SD = 8'h19;
  localparam logic [7:0] A_LOC_SD = 8'h20;
  localparam logic [7:0] A_HYST = 8'h21;
  localparam logic [7:0] A_FILT = 8'h22;
  localparam logic [7:0] RD_MAKER = 8'hfe;
  localparam logic [7:0] RD_REV = 8'hff;
  // ------------------------------------------------------------
  // fields, masks, timing
  // ------------------------------------------------------------
  localparam int SETUP_STANDBY_BIT = 6;
  localparam int FILT_TMO_BIT = 7;
  localparam logic [7:0] OFS_LO_MASK = 8'hc0;
  localparam logic [7:0] RATE_MASK = 8'h0f;
  localparam logic [2:0] MAX_RUN = 3'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int TIMEOUT_MS = 25;
  localparam int CLK_MHZ = 100;
  localparam int TMO_W = 22;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_DATA, ST_READ, ST_SKIP} tmon_bus_st_type;
  typedef struct packed {
    logic busy; logic lhigh; logic llow; logic rhigh; logic rlow; logic open; logic rthrm; logic lthrm;
  } tmon_status_type;
  typedef struct packed {
    logic [7:0] local_val;
    logic [9:0] remote_val;
    logic remote_open;
  } tmon_meas_type;
  typedef struct packed {
    logic [7:0] setup, rate, loc_ul, loc_ll, rem_ul_hi, rem_ll_hi, rem_ul_lo, rem_ll_lo;
    logic [7:0] ofs_hi, ofs_lo, rem_sd, loc_sd, hyst, filt, loc_val, rem_hi, rem_lo;
  } tmon_regs_type;
  localparam tmon_regs_type RST_REGS = '{setup: 8'h00, rate: 8'h08, loc_ul: 8'h55, loc_ll: 8'h00,
    rem_ul_hi: 8'h55, rem_ll_hi: 8'h00, rem_ul_lo: 8'h00, rem_ll_lo: 8'h00, ofs_hi: 8'h00,
    ofs_lo: 8'h00, rem_sd: 8'h55, loc_sd: 8'h55, hyst: 8'h0a, filt: 8'h01, loc_val: 8'h00,
    rem_hi: 8'h00, rem_lo: 8'h00};
  typedef struct packed {
    logic [2:0] scl_s, sda_s;
    tmon_bus_st_type st;
    logic [3:0] cnt;
    logic [7:0] shreg, ptr, tx;
    logic ack, drv, os, alert;
    logic [TMO_W-1:0] tmo;
    tmon_regs_type regs;
    tmon_status_type stat;
    logic [4:0] cond;
    logic [2:0] run;
  } tmon_core_type;
endpackage

// file: design/tmon_regmap.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - remote offset is 10-bit twos complement, high byte 0x11, low byte 0x12
// - only offset low bits 7:6 count, quarter degrees; high bit 7 is sign
// - offset spans -128 to +127.75 degrees in quarter steps
// - offset is added to every remote measurement before use
// - offset is zero after reset
// - write to 0x0f in standby runs one conversion of both channels
// - one-shot data byte is ignored and not stored
// - alert filter bits 3:1 select one to four consecutive violations
// - default needs one violation; four is the maximum
// - no averaging, the consecutive filter is the only smoothing
// - local high limit read 0x05, write 0x0b, default 0x55
// - remote high limit read 0x07, write 0x0d, default 0x55; low byte 0x13
// - remote low value byte read at 0x10, never written
// - the device only answers as a bus slave
// - bit 7 of 0x22 enables a 25 ms inactivity timeout, off at reset
// - first write byte loads the pointer, second goes to pointed register
// - writes carry one or two bytes, reads return exactly one byte
module tmon_regmap #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h01, // arbitrary value
  parameter int unsigned TIMEOUT_CYC = tmon_pkg::TIMEOUT_MS * 1000 * tmon_pkg::CLK_MHZ
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic meas_valid,
  input wire tmon_pkg::tmon_meas_type meas,
  output logic conv_start,
  output logic convert_enable,
  output logic [3:0] rate_code,
  output logic alert_n,
  output logic overtemp_shutdown_out_n
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] need_count(input logic [7:0] f);
    need_count = 3'(f[1]) + 3'(f[2]) + 3'(f[3]) + 3'h1;
  endfunction

  function automatic logic [7:0] rd_mux(input tmon_pkg::tmon_core_type c, input logic [7:0] a);
    case (a)
      tmon_pkg::RD_LOC_VAL: rd_mux = c.regs.loc_val;
      tmon_pkg::RD_REM_HI: rd_mux = c.regs.rem_hi;
      tmon_pkg::RD_STATUS: rd_mux = c.stat;
      tmon_pkg::RD_SETUP: rd_mux = c.regs.setup;
      tmon_pkg::RD_RATE: rd_mux = c.regs.rate;
      tmon_pkg::RD_LOC_UL: rd_mux = c.regs.loc_ul;
      tmon_pkg::RD_LOC_LL: rd_mux = c.regs.loc_ll;
      tmon_pkg::RD_REM_UL_HI: rd_mux = c.regs.rem_ul_hi;
      tmon_pkg::RD_REM_LL_HI: rd_mux = c.regs.rem_ll_hi;
      tmon_pkg::RD_REM_LO: rd_mux = c.regs.rem_lo;
      tmon_pkg::A_OFS_HI: rd_mux = c.regs.ofs_hi;
      tmon_pkg::A_OFS_LO: rd_mux = c.regs.ofs_lo;
      tmon_pkg::A_REM_UL_LO: rd_mux = c.regs.rem_ul_lo;
      tmon_pkg::A_REM_LL_LO: rd_mux = c.regs.rem_ll_lo;
      tmon_pkg::A_REM_SD: rd_mux = c.regs.rem_sd;
      tmon_pkg::A_LOC_SD: rd_mux = c.regs.loc_sd;
      tmon_pkg::A_HYST: rd_mux = c.regs.hyst;
      tmon_pkg::A_FILT: rd_mux = c.regs.filt;
      tmon_pkg::RD_MAKER: rd_mux = MAKER_ID;
      tmon_pkg::RD_REV: rd_mux = REV_ID;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // value registers and the one-shot address have no storage for writes
  function automatic tmon_pkg::tmon_regs_type reg_write(input tmon_pkg::tmon_regs_type r, input logic [7:0] a,
                                                       input logic [7:0] v);
    reg_write = r;
    case (a)
      tmon_pkg::WR_SETUP: reg_write.setup = v;
      tmon_pkg::WR_RATE: reg_write.rate = v & tmon_pkg::RATE_MASK;
      tmon_pkg::WR_LOC_UL: reg_write.loc_ul = v;
      tmon_pkg::WR_LOC_LL: reg_write.loc_ll = v;
      tmon_pkg::WR_REM_UL_HI: reg_write.rem_ul_hi = v;
      tmon_pkg::WR_REM_LL_HI: reg_write.rem_ll_hi = v;
      tmon_pkg::A_OFS_HI: reg_write.ofs_hi = v;
      tmon_pkg::A_OFS_LO: reg_write.ofs_lo = v & tmon_pkg::OFS_LO_MASK;
      tmon_pkg::A_REM_UL_LO: reg_write.rem_ul_lo = v;
      tmon_pkg::A_REM_LL_LO: reg_write.rem_ll_lo = v;
      tmon_pkg::A_REM_SD: reg_write.rem_sd = v;
      tmon_pkg::A_LOC_SD: reg_write.loc_sd = v;
      tmon_pkg::A_HYST: reg_write.hyst = v;
      tmon_pkg::A_FILT: reg_write.filt = v;
      default: reg_write = r;
    endcase
  endfunction

  // ------------------------------------------------------------
  // link side: data bit caught by the bus clock
  // ------------------------------------------------------------
  // held stable until the next scl rise, which is read only after the
  // synchronised scl edge, so a single data bit crosses safely
  logic sda_cap_q;
  always_ff @(posedge scl) begin
    sda_cap_q <= sda_in;
  end

  // ------------------------------------------------------------
  // core state
  // ------------------------------------------------------------
  tmon_pkg::tmon_core_type core_q, core_d;
  logic scl_rise, scl_fall, bus_start, bus_stop, meas_take, any_bad, wr_hit, ptr_load, rd_take;
  logic [7:0] rx_byte, lth, rth;
  logic [9:0] ofs10, rem10;
  logic [2:0] need;

  assign ofs10 = {core_q.regs.ofs_hi, core_q.regs.ofs_lo[7:6]};
  assign rem10 = 10'(meas.remote_val + ofs10);
  assign need = need_count(core_q.regs.filt);

  always_comb begin
    core_d = core_q;
    core_d.scl_s = {core_q.scl_s[1:0], scl};
    core_d.sda_s = {core_q.sda_s[1:0], sda_in};
    core_d.os = 1'b0;
    scl_rise = core_q.scl_s[1] & ~core_q.scl_s[2];
    scl_fall = ~core_q.scl_s[1] & core_q.scl_s[2];
    bus_start = core_q.scl_s[1] & core_q.scl_s[2] & ~core_q.sda_s[1] & core_q.sda_s[2];
    bus_stop = core_q.scl_s[1] & core_q.scl_s[2] & core_q.sda_s[1] & ~core_q.sda_s[2];
    rx_byte = {core_q.shreg[6:0], sda_cap_q};
    wr_hit = 1'b0;
    ptr_load = 1'b0;
    rd_take = 1'b0;
    // ------------------------------------------------------------
    // slave byte engine
    // ------------------------------------------------------------
    if (scl_rise) begin
      if (core_q.cnt == tmon_pkg::BYTE_BITS) begin
        core_d.cnt = 4'h0;
        core_d.ack = 1'b0;
        // ack still set marks the address byte; only the data byte ends read state
        if (core_q.st == tmon_pkg::ST_READ && !core_q.ack) begin
          core_d.st = tmon_pkg::ST_SKIP;
        end
      end else begin
        core_d.shreg = rx_byte;
        core_d.cnt = core_q.cnt + 4'h1;
        if (core_q.cnt == tmon_pkg::BYTE_BITS - 4'h1) begin
          unique case (core_q.st)
            tmon_pkg::ST_ADDR: begin
              if (rx_byte[7:1] == DEV_ADDR) begin
                core_d.ack = 1'b1;
                if (rx_byte[0]) begin
                  core_d.st = tmon_pkg::ST_READ;
                  core_d.tx = rd_mux(core_q, core_q.ptr);
                  rd_take = 1'b1;
                end else begin
                  core_d.st = tmon_pkg::ST_PTR;
                end
              end else begin
                core_d.st = tmon_pkg::ST_SKIP;
              end
            end
            tmon_pkg::ST_PTR: begin
              core_d.ptr = rx_byte;
              ptr_load = 1'b1;
              core_d.ack = 1'b1;
              core_d.st = tmon_pkg::ST_DATA;
            end
            tmon_pkg::ST_DATA: begin
              wr_hit = 1'b1;
              core_d.ack = 1'b1;
              core_d.st = tmon_pkg::ST_SKIP;
            end
            tmon_pkg::ST_IDLE, tmon_pkg::ST_READ, tmon_pkg::ST_SKIP: begin
            end
          endcase
        end
      end
    end
    if (scl_fall) begin
      if (core_q.cnt == tmon_pkg::BYTE_BITS) begin
        core_d.drv = core_q.ack;
      end else begin
        core_d.drv = (core_q.st == tmon_pkg::ST_READ) & ~core_q.tx[3'(4'h7 - core_q.cnt)];
      end
    end
    // inactivity timeout frees a hung bus
    if (core_q.regs.filt[tmon_pkg::FILT_TMO_BIT] && core_q.st != tmon_pkg::ST_IDLE) begin
      core_d.tmo = (scl_rise | scl_fall) ? '0 : core_q.tmo + 1'b1;
      if (core_q.tmo == tmon_pkg::TMO_W'(TIMEOUT_CYC - 1)) begin
        core_d.st = tmon_pkg::ST_IDLE;
        core_d.drv = 1'b0;
        core_d.tmo = '0;
      end
    end else begin
      core_d.tmo = '0;
    end
    if (bus_start) begin
      core_d.st = tmon_pkg::ST_ADDR;
      core_d.cnt = 4'h0;
      core_d.ack = 1'b0;
      core_d.drv = 1'b0;
    end else if (bus_stop) begin
      core_d.st = tmon_pkg::ST_IDLE;
      core_d.drv = 1'b0;
    end
    // ------------------------------------------------------------
    // status clear by read, then measurement (set wins)
    // ------------------------------------------------------------
    if (rd_take && core_q.ptr == tmon_pkg::RD_STATUS) begin
      {core_d.stat.lhigh, core_d.stat.llow, core_d.stat.rhigh, core_d.stat.rlow, core_d.stat.open} =
        {core_q.stat.lhigh, core_q.stat.llow, core_q.stat.rhigh, core_q.stat.rlow, core_q.stat.open}
        & core_q.cond;
    end
    // in standby an unfinished conversion is dropped without a result
    meas_take = meas_valid & (~core_q.regs.setup[tmon_pkg::SETUP_STANDBY_BIT] | core_q.stat.busy);
    any_bad = 1'b0;
    lth = core_q.regs.loc_sd - core_q.regs.hyst;
    rth = core_q.regs.rem_sd - core_q.regs.hyst;
    if (meas_take) begin
      core_d.stat.busy = 1'b0;
      core_d.regs.loc_val = meas.local_val;
      core_d.regs.rem_hi = rem10[9:2];
      core_d.regs.rem_lo = {rem10[1:0], 6'h00};
      core_d.cond = {meas.local_val > core_q.regs.loc_ul, meas.local_val <= core_q.regs.loc_ll,
                     rem10 > {core_q.regs.rem_ul_hi, core_q.regs.rem_ul_lo[7:6]},
                     rem10 <= {core_q.regs.rem_ll_hi, core_q.regs.rem_ll_lo[7:6]}, meas.remote_open};
      any_bad = |core_d.cond;
      {core_d.stat.lhigh, core_d.stat.llow, core_d.stat.rhigh, core_d.stat.rlow, core_d.stat.open} =
        {core_d.stat.lhigh, core_d.stat.llow, core_d.stat.rhigh, core_d.stat.rlow, core_d.stat.open}
        | core_d.cond;
      // no averaging upstream, so this run counter is the only filter
      if (!any_bad) begin
        core_d.run = 3'h0;
      end else if (core_q.run != tmon_pkg::MAX_RUN) begin
        core_d.run = core_q.run + 3'h1;
      end
      if (meas.local_val > core_q.regs.loc_sd) begin
        core_d.stat.lthrm = 1'b1;
      end else if (meas.local_val <= lth) begin
        core_d.stat.lthrm = 1'b0;
      end
      if (rem10[9:2] > core_q.regs.rem_sd) begin
        core_d.stat.rthrm = 1'b1;
      end else if (rem10[9:2] <= rth) begin
        core_d.stat.rthrm = 1'b0;
      end
    end
    if (core_d.run >= need) begin
      core_d.alert = 1'b1;
    end else if (!(core_d.stat.lhigh | core_d.stat.llow | core_d.stat.rhigh | core_d.stat.rlow
                   | core_d.stat.open)) begin
      core_d.alert = 1'b0;
    end
    // ------------------------------------------------------------
    // register writes and one-shot
    // ------------------------------------------------------------
    if (wr_hit) begin
      core_d.regs = reg_write(core_d.regs, core_q.ptr, rx_byte);
      if (core_q.ptr == tmon_pkg::WR_ONE_SHOT && core_q.regs.setup[tmon_pkg::SETUP_STANDBY_BIT]
          && !core_q.stat.busy) begin
        core_d.os = 1'b1;
        core_d.stat.busy = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      core_q <= '{st: tmon_pkg::ST_IDLE, regs: tmon_pkg::RST_REGS, scl_s: 3'h7, sda_s: 3'h7, default: '0};
    end else begin
      core_q <= core_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = core_q.drv;
  assign conv_start = core_q.os;
  assign convert_enable = ~core_q.regs.setup[tmon_pkg::SETUP_STANDBY_BIT] | core_q.stat.busy;
  assign rate_code = core_q.regs.rate[3:0];
  assign alert_n = ~core_q.alert;
  assign overtemp_shutdown_out_n = ~(core_q.stat.lthrm | core_q.stat.rthrm);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_ofs_rst;
    @(posedge mclk) $fell(rst) |-> ofs10 == 10'h000;
  endproperty
  a_ofs_rst: assert property (p_ofs_rst) else $error("offset not zero after reset");

  property p_ofs_add;
    @(posedge mclk) disable iff (rst)
      meas_take |=> {core_q.regs.rem_hi, core_q.regs.rem_lo[7:6]} == 10'($past(meas.remote_val) + $past(ofs10));
  endproperty
  a_ofs_add: assert property (p_ofs_add) else $error("remote result lacks offset");

  property p_ofs_lo;
    @(posedge mclk) disable iff (rst) core_q.regs.ofs_lo[5:0] == 6'h00;
  endproperty
  a_ofs_lo: assert property (p_ofs_lo) else $error("offset low byte holds unused bits");

  property p_one_shot;
    @(posedge mclk) disable iff (rst)
      wr_hit && core_q.ptr == tmon_pkg::WR_ONE_SHOT && core_q.regs.setup[tmon_pkg::SETUP_STANDBY_BIT]
      && !core_q.stat.busy |=> conv_start ##1 !conv_start;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot did not raise conv_start for one cycle");

  property p_os_nostore;
    @(posedge mclk) disable iff (rst)
      wr_hit && core_q.ptr == tmon_pkg::WR_ONE_SHOT && !meas_valid |=> core_q.regs == $past(core_q.regs);
  endproperty
  a_os_nostore: assert property (p_os_nostore) else $error("one-shot data was stored");

  property p_filter;
    @(posedge mclk) disable iff (rst) $rose(core_q.alert) |-> core_q.run >= need && core_q.run <= tmon_pkg::MAX_RUN;
  endproperty
  a_filter: assert property (p_filter) else $error("alert before consecutive count");

  property p_run_clear;
    @(posedge mclk) disable iff (rst) meas_take && !any_bad |=> core_q.run == 3'h0;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run counter not restarted");

  property p_loc_ul;
    @(posedge mclk) disable iff (rst)
      wr_hit && core_q.ptr == tmon_pkg::WR_LOC_UL |=> core_q.regs.loc_ul == $past(rx_byte);
  endproperty
  a_loc_ul: assert property (p_loc_ul) else $error("local high limit write lost");

  property p_tmo_off;
    @(posedge mclk) disable iff (rst) !core_q.regs.filt[tmon_pkg::FILT_TMO_BIT] |=> core_q.tmo == '0;
  endproperty
  a_tmo_off: assert property (p_tmo_off) else $error("timeout counts while disabled");

  property p_ptr;
    @(posedge mclk) disable iff (rst) ptr_load |=> core_q.ptr == $past(rx_byte) && core_q.st == tmon_pkg::ST_DATA;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not loaded from first byte");

  c_write: cover property (@(posedge mclk) disable iff (rst) wr_hit);
  c_read: cover property (@(posedge mclk) disable iff (rst) rd_take);
  c_alert: cover property (@(posedge mclk) disable iff (rst) $rose(core_q.alert));
  c_shot: cover property (@(posedge mclk) disable iff (rst) conv_start);
endmodule
`default_nettype wire

// file: testbench/tmon_host.sv
`timescale 1ns/1ps
`default_nettype none
module tmon_host #(
  parameter logic [6:0] DEV = 7'h2a
) (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_in
);
  // ------------------------------------------------------------
  // link clock; scl only moves inside a frame, idle high
  // ------------------------------------------------------------
  logic lclk;
  int nacks;
  initial begin
    lclk = 1'b0;
    scl = 1'b1;
    sda_pull = 1'b0;
    nacks = 0;
    #3;
    forever #7.5 lclk = ~lclk;
  end
  // ------------------------------------------------------------
  // bit and byte level; phases of 75 ns so the synchroniser sees every edge
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
    #1;
  endtask
  task automatic start();
    sda_pull = 1'b1;
    tick(5);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(5);
    sda_pull = 1'b0;
    tick(5);
  endtask
  task automatic bit_out(input logic b);
    sda_pull = ~b;
    tick(5);
    scl = 1'b1;
    tick(5);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic bit_in(output logic b);
    sda_pull = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(2);
    b = sda_in;
    tick(3);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic byte_out(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(a);
    if (a !== 1'b0) nacks++;
  endtask
  // pointer byte first, optional data byte second
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic two);
    start();
    byte_out({DEV, 1'b0});
    byte_out(p);
    if (two) byte_out(d);
    stop();
  endtask
  // a read is one byte closed by a nack
  task automatic rd(output logic [7:0] d);
    start();
    byte_out({DEV, 1'b1});
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1);
    stop();
  endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic w; logic [7:0] wa, wd, ra, ex;} tmon_row_type;
  logic mclk, rst, scl, sda_pull, sda_in, sda_out, sda_oe, meas_valid, conv_start;
  logic convert_enable, alert_n, overtemp_shutdown_out_n;
  logic [3:0] rate_code;
  logic [7:0] d;
  tmon_pkg::tmon_meas_type meas;
  int fails, compares, starts;
  tmon_row_type rows [20] = '{
    '{0, 0, 0, 8'h03, 8'h00}, '{0, 0, 0, 8'h04, 8'h08}, '{0, 0, 0, 8'h05, 8'h55}, '{0, 0, 0, 8'h07, 8'h55},
    '{0, 0, 0, 8'h11, 8'h00}, '{0, 0, 0, 8'h12, 8'h00}, '{0, 0, 0, 8'h22, 8'h01}, '{0, 0, 0, 8'h19, 8'h55},
    '{0, 0, 0, 8'h20, 8'h55}, '{0, 0, 0, 8'h21, 8'h0a}, '{0, 0, 0, 8'h13, 8'h00}, '{0, 0, 0, 8'h10, 8'h00},
    '{1, 8'h0b, 8'h3c, 8'h05, 8'h3c}, '{1, 8'h05, 8'h77, 8'h05, 8'h3c}, '{1, 8'h0d, 8'h66, 8'h07, 8'h66},
    '{1, 8'h13, 8'hc0, 8'h13, 8'hc0}, '{1, 8'h12, 8'hff, 8'h12, 8'hc0}, '{1, 8'h11, 8'h01, 8'h11, 8'h01},
    '{1, 8'h10, 8'h12, 8'h10, 8'h00}, '{1, 8'h0a, 8'hf5, 8'h04, 8'h05}};
  assign sda_in = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
  always @(posedge mclk) if (conv_start === 1'b1) starts++;
  tmon_regmap #(.TIMEOUT_CYC(200)) u_tmon_regmap (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .meas_valid(meas_valid), .meas(meas), .conv_start(conv_start),
    .convert_enable(convert_enable), .rate_code(rate_code), .alert_n(alert_n),
    .overtemp_shutdown_out_n(overtemp_shutdown_out_n));
  tmon_host u_tmon_host (.scl(scl), .sda_pull(sda_pull), .sda_in(sda_in));
  // ------------------------------------------------------------
  // compare and helper tasks
  // ------------------------------------------------------------
  task automatic check_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_pin(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic rdreg(input logic [7:0] a, output logic [7:0] v);
    u_tmon_host.wr(a, 8'h00, 1'b0);
    u_tmon_host.rd(v);
  endtask
  // value registers load on the first edge that sees the strobe; the task then waits four more edges
  task automatic measure(input logic [7:0] l, input logic [9:0] r);
    @(posedge mclk);
    #1;
    meas = '{local_val: l, remote_val: r, remote_open: 1'b0};
    meas_valid = 1'b1;
    @(posedge mclk);
    #1;
    meas_valid = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #900us;
    fails++;
    test_done();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    fails = 0;
    compares = 0;
    starts = 0;
    rst = 1'b1;
    meas_valid = 1'b0;
    meas = '0;
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    check_pin("alert_n", 1'b1, alert_n);
    check_reg("rate_code", 8'h08, {4'h0, rate_code});
    repeat (3) @(posedge mclk);
    foreach (rows[i]) begin
      if (rows[i].w) u_tmon_host.wr(rows[i].wa, rows[i].wd, 1'b1);
      rdreg(rows[i].ra, d);
      check_reg("register", rows[i].ex, d);
    end
    check_reg("rate_code", 8'h05, {4'h0, rate_code});
    $display("test register table done");
    // offset now +1.75 degrees: 0x064 + 0x007 = 0x06b
    measure(8'h20, 10'h064);
    rdreg(8'h01, d);
    check_reg("remote high", 8'h1a, d);
    rdreg(8'h10, d);
    check_reg("remote low", 8'hc0, d);
    $display("test offset done");
    u_tmon_host.wr(8'h22, 8'h02, 1'b1);
    measure(8'h50, 10'h064);
    measure(8'h20, 10'h064);
    measure(8'h50, 10'h064);
    check_pin("alert_n", 1'b1, alert_n);
    measure(8'h50, 10'h064);
    check_pin("alert_n", 1'b0, alert_n);
    $display("test alert filter done");
    u_tmon_host.wr(8'h11, 8'h80, 1'b1);
    u_tmon_host.wr(8'h12, 8'h00, 1'b1);
    measure(8'h20, 10'h064);
    rdreg(8'h01, d);
    check_reg("remote high", 8'h99, d);
    check_pin("overtemp_shutdown_out_n", 1'b0, overtemp_shutdown_out_n);
    rdreg(8'h02, d);
    check_reg("status", 8'h52, d);
    u_tmon_host.rd(d);
    check_reg("status again", 8'h12, d);
    $display("test negative offset done");
    u_tmon_host.wr(8'h09, 8'h40, 1'b1);
    check_pin("convert_enable", 1'b0, convert_enable);
    starts = 0;
    u_tmon_host.wr(8'h0f, 8'ha5, 1'b1);
    check_reg("starts", 8'h01, starts[7:0]);
    check_pin("convert_enable", 1'b1, convert_enable);
    measure(8'h20, 10'h064);
    check_pin("convert_enable", 1'b0, convert_enable);
    // keep off the bus for a while after the conversion
    repeat (100) @(posedge mclk);
    $display("test one shot done");
    u_tmon_host.wr(8'h22, 8'h82, 1'b1);
    u_tmon_host.start();
    for (int i = 7; i >= 0; i--) u_tmon_host.bit_out(i == 0 ? 1'b0 : u_tmon_host.DEV[i - 1]);
    repeat (8) @(posedge mclk);
    check_pin("sda_oe", 1'b1, sda_oe);
    repeat (250) @(posedge mclk);
    check_pin("sda_oe", 1'b0, sda_oe);
    u_tmon_host.stop();
    rdreg(8'h22, d);
    check_reg("alert filter", 8'h82, d);
    check_reg("nacks", 8'h00, u_tmon_host.nacks[7:0]);
    $display("test timeout done");
    test_done();
  end
endmodule
`default_nettype wire
